// ===== common/resonant_prot_pkg.sv
// constants and types shared by the protection and optobias logic
// Function
// RQ1: regulate optocurrent slowly toward 85 uA target
// RQ2: below 1020 mV sense level, ramp offset up
// RQ3: optocurrent above target lowers the power offset
// RQ4: optocurrent drop immediately raises capacitor swing
// RQ5: minimum-power low-power mode above 106 uA: burst
// RQ6: in burst, dropping below threshold starts burst
// RQ7: supply undervoltage: stop, recharge, pull boost low
// RQ8: restart only when both supplies above start
// RQ9: bootstrap below reset level keeps high-side off
// RQ10: no switching before boost sense start level
// RQ11: boost undervoltage stops; restart above start level
// RQ12: output overvoltage after 5 consecutive cycles
// RQ13: one ADC alternates output and boost samples
// RQ14: overvoltage latches off and disables boost stage
// RQ15: latch cleared only by power removal
// RQ16: overcurrent cuts conduction; 5 cycles: overpower response
// RQ17: overpower response latched or safe restart, selectable
// RQ18: latched or restart: regulate supply via HV
// RQ19: capacitive-mode handling never stops or disables boost
// RQ20: overpower swing runs 50/200 ms timer, then protect
// RQ21: fault-free cycle clears consecutive fault counter
package resonant_prot_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;            // system clock rate
    localparam int CYC_PER_MS = CLK_HZ / 1000;     // cycles in one ms
    localparam int OPP_SHORT_MS = 50;              // short overpower delay
    localparam int OPP_LONG_MS = 200;              // long overpower delay
    localparam int RESTART_MS = 1000;              // safe restart pause
    localparam int OPP_SHORT_CYC = OPP_SHORT_MS * CYC_PER_MS;
    localparam int OPP_LONG_CYC = OPP_LONG_MS * CYC_PER_MS;
    localparam int RESTART_CYC = RESTART_MS * CYC_PER_MS;
    localparam int OFFSET_STEP_US = 100;           // slow offset step period
    localparam int OFFSET_STEP_CYC = OFFSET_STEP_US * CLK_HZ / 1_000_000;
    localparam int TIMER_W = 25;                   // holds RESTART_CYC
    localparam int STEP_W = 12;                    // holds OFFSET_STEP_CYC
    // ---------------------------------------------------------------
    // feedback levels, optocurrent in uA codes
    // ---------------------------------------------------------------
    localparam int OPTO_W = 10;                    // optocurrent code width
    localparam int FB_TARGET_MV = 1020;            // sense voltage target
    localparam int FB_R_KOHM = 12;                 // internal sense resistor
    localparam logic [9:0] OPTO_TARGET_UA = 10'(FB_TARGET_MV / FB_R_KOHM);
    localparam logic [9:0] BURST_START_UA = 10'h06a; // 106 uA
    localparam int OFFSET_W = 8;                   // power offset width
    localparam logic [7:0] OFFSET_MAX = 8'hff;     // offset ceiling
    localparam logic [7:0] OFFSET_RST = 8'h00;     // offset after reset
    // ---------------------------------------------------------------
    // fault counting and adc
    // ---------------------------------------------------------------
    localparam int TRIP_CYCLES = 5;                // consecutive-cycle trip
    localparam int ADC_W = 10;                     // shared adc width
    localparam logic ADC_OUT = 1'b0;               // select: output sense
    localparam logic ADC_BOOST = 1'b1;             // select: boost sense
    // ---------------------------------------------------------------
    // protection state codes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SUPPLY  = 3'h0,                         // recharging supplies
        ST_BOOST   = 3'h1,                         // waiting boost start
        ST_RUN     = 3'h2,                         // switching
        ST_RESTART = 3'h3,                         // safe restart pause
        ST_LATCHED = 3'h4                          // latched off
    } state_type;
endpackage : resonant_prot_pkg

// ===== hw/pin_sync.sv
// two-flop synchroniser for asynchronous comparator inputs
`timescale 1ns/10ps
module pin_sync
    import resonant_prot_pkg::*;
#(
    parameter int W = 1                            // number of bits
)(
    input wire logic clk,                          // system clock
    input wire logic rstn,                         // async reset, low
    input wire logic ce,                           // clock enable
    input wire logic [W-1:0] d,                    // raw asynchronous bits
    output logic [W-1:0] q                         // synchronised bits
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;                          // first stage, only s2 reads
        logic [W-1:0] s2;                          // second stage
    } sync_type;
    sync_type st_reg;
    sync_type st_next;

    // next state: shift one stage
    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            st_next.s1 = d;
            st_next.s2 = st_reg.s1;
        end
    end

    // register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign q = st_reg.s2;
endmodule : pin_sync

// ===== hw/consec_counter.sv
// counts uninterrupted runs of faulty switching cycles
`timescale 1ns/10ps
module consec_counter
    import resonant_prot_pkg::*;
#(
    parameter int N = TRIP_CYCLES                  // cycles to trip
)(
    input wire logic clk,                          // system clock
    input wire logic rstn,                         // async reset, low
    input wire logic ce,                           // clock enable
    input wire logic cycle_end,                    // a switching cycle ended
    input wire logic fault,                        // fault seen in that cycle
    input wire logic clear,                        // drop the count
    output logic trip                              // N faulty cycles in a row
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cnt;                           // saturating run length
    } cnt_type;
    cnt_type st_reg;
    cnt_type st_next;

    // count faulty cycles, restart on any clean one
    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            if (clear)
                st_next.cnt = 4'h0;
            else if (cycle_end && !fault)
                st_next.cnt = 4'h0;                // [RQ21]
            else if (cycle_end && st_reg.cnt != 4'(N))
                st_next.cnt = st_reg.cnt + 4'h1;
        end
    end

    // register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign trip = (st_reg.cnt == 4'(N));
endmodule : consec_counter

// ===== hw/resonant_protection_and_optobias_fsm.sv
// protection state machine, optobias offset loop and burst trigger
`timescale 1ns/10ps
module resonant_protection_and_optobias_fsm
    import resonant_prot_pkg::*;
#(
    parameter int OPP_SHORT = OPP_SHORT_CYC, // short overpower delay
    parameter int OPP_LONG = OPP_LONG_CYC, // long overpower delay
    parameter int RESTART = RESTART_CYC, // safe restart pause
    parameter logic [9:0] OVP_LEVEL = 10'h300, // output overvoltage code
    parameter logic [9:0] BOOST_START = 10'h280, // boost start code
    parameter logic [9:0] BOOST_UVP = 10'h200 // boost undervoltage code
)(
    input wire logic CLK, // 20 MHz system clock
    input wire logic RSTN, // power-on reset, low
    input wire logic CE, // clock enable
    input wire logic CONTROLLER_SUPPLY_BELOW_UV, // controller supply low
    input wire logic CONTROLLER_SUPPLY_ABOVE_START, // controller supply ok
    input wire logic REGULATED_SUPPLY_BELOW_UV, // regulated supply low
    input wire logic REGULATED_SUPPLY_ABOVE_START, // regulated supply ok
    input wire logic BOOTSTRAP_ABOVE_RST, // high-side supply ok
    input wire logic OCP_COMP, // current above limit
    input wire logic OTP_COMP, // die too hot
    input wire logic SWING_ABOVE_OPP, // cap swing over threshold
    input wire logic CAP_MODE_NEAR, // near capacitive mode
    input wire logic CYCLE_END, // switching cycle done
    input wire logic ADC_VALID, // adc sample ready
    input wire logic [9:0] ADC_DATA, // adc sample
    input wire logic [9:0] OPTO_CURRENT, // optocurrent, uA code
    input wire logic LOWPOW_AT_MIN, // min energy and duty
    input wire logic OPP_LATCH_SEL, // 1 latch, 0 safe restart
    input wire logic OPP_LONG_SEL, // 1 long, 0 short delay
    input wire logic OPP_TIMER_OFF, // overpower timer off
    output logic SWITCH_EN, // converter may switch
    output logic HS_GATE_EN, // high-side may turn on
    output logic CONDUCTION_CUT, // end active switch now
    output logic CAP_MODE_CUT, // early turn-off request
    output logic BOOST_SENSE_O, // boost sense drive value
    output logic BOOST_SENSE_OE, // pull boost sense low
    output logic HV_RECHARGE_EN, // recharge both supplies
    output logic HV_REG_START, // hold supply at start
    output logic [7:0] POWER_OFFSET, // slow power offset
    output logic [9:0] SWING_BOOST, // fast swing increase
    output logic BURST_MODE, // burst mode active
    output logic BURST_START, // start a burst, pulse
    output logic ADC_SELECT, // adc channel selected
    output logic [2:0] PROT_STATE // protection state
);
    // ---------------------------------------------------------------
    // synchronised comparator inputs
    // ---------------------------------------------------------------
    logic [8:0] raw_pins;                          // asynchronous pin levels
    logic [8:0] pins;                              // after two flops
    logic controller_supply_uv, controller_supply_ok, regulated_supply_uv, regulated_supply_ok; // supply levels
    logic bs_ok, ocp, otp, swing_opp, cap_near;    // other comparators

    assign raw_pins = {CONTROLLER_SUPPLY_BELOW_UV, CONTROLLER_SUPPLY_ABOVE_START, REGULATED_SUPPLY_BELOW_UV,
                       REGULATED_SUPPLY_ABOVE_START, BOOTSTRAP_ABOVE_RST, OCP_COMP,
                       OTP_COMP, SWING_ABOVE_OPP, CAP_MODE_NEAR};
    assign {controller_supply_uv, controller_supply_ok, regulated_supply_uv, regulated_supply_ok, bs_ok, ocp,
            otp, swing_opp, cap_near} = pins;

    pin_sync #(.W(9)) u_sync (
        .clk(CLK),
        .rstn(RSTN),
        .ce(CE),
        .d(raw_pins),
        .q(pins)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        state_type state;                          // protection state
        logic [TIMER_W-1:0] timer;                 // overpower or restart
        logic [STEP_W-1:0] step;                   // offset step divider
        logic boost_ok;                            // boost hysteresis result
        logic ovp_now;                             // last output sample high
        logic ocp_cyc;                             // overcurrent this cycle
        logic ovp_cyc;                             // overvoltage this cycle
        logic sw_en;                               // output copies below
        logic hs_en;
        logic cut;
        logic cap_cut;
        logic bst_oe;
        logic hv_chg;
        logic hv_reg;
        logic [OFFSET_W-1:0] offset;
        logic [OPTO_W-1:0] swing;
        logic burst;
        logic burst_go;
        logic adc_sel;
    } top_type;
    top_type st_reg;
    top_type st_next;

    // ---------------------------------------------------------------
    // consecutive-cycle fault counters
    // ---------------------------------------------------------------
    logic ovp_trip, ocp_trip;                      // five-in-a-row flags
    logic run_clear;                               // counters idle outside run
    assign run_clear = (st_reg.state != ST_RUN);

    consec_counter #(.N(TRIP_CYCLES)) u_ovp_cnt (
        .clk(CLK),
        .rstn(RSTN),
        .ce(CE),
        .cycle_end(CYCLE_END),
        .fault(st_reg.ovp_cyc || st_reg.ovp_now),
        .clear(run_clear),
        .trip(ovp_trip)
    );

    consec_counter #(.N(TRIP_CYCLES)) u_ocp_cnt (
        .clk(CLK),
        .rstn(RSTN),
        .ce(CE),
        .cycle_end(CYCLE_END),
        .fault(st_reg.ocp_cyc || ocp),
        .clear(run_clear),
        .trip(ocp_trip)
    );

    // ---------------------------------------------------------------
    // helper terms
    // ---------------------------------------------------------------
    logic supply_uv;                               // either supply low
    logic supply_ok;                               // both above start
    logic [TIMER_W-1:0] opp_limit;                 // selected overpower delay
    state_type opp_dest;                           // selected response
    assign supply_uv = controller_supply_uv || regulated_supply_uv;
    assign supply_ok = controller_supply_ok && regulated_supply_ok;       // [RQ8]
    assign opp_limit = OPP_LONG_SEL ? TIMER_W'(OPP_LONG)
                                    : TIMER_W'(OPP_SHORT);
    assign opp_dest = OPP_LATCH_SEL ? ST_LATCHED : ST_RESTART; // [RQ17]

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.burst_go = 1'b0;
        if (CE)
        begin
            // shared adc: alternate channels, one sample each
            if (ADC_VALID)
            begin
                st_next.adc_sel = ~st_reg.adc_sel;      // [RQ13]
                if (st_reg.adc_sel == ADC_OUT)
                    st_next.ovp_now = (ADC_DATA > OVP_LEVEL);
                else if (ADC_DATA > BOOST_START)
                    st_next.boost_ok = 1'b1;
                else if (ADC_DATA < BOOST_UVP)
                    st_next.boost_ok = 1'b0;
            end

            // per-cycle fault flags; a new event wins over the clear
            if (CYCLE_END)
            begin
                st_next.ocp_cyc = ocp;
                st_next.ovp_cyc = st_next.ovp_now;
            end
            else
            begin
                st_next.ocp_cyc = st_reg.ocp_cyc || ocp;
                st_next.ovp_cyc = st_reg.ovp_cyc || st_next.ovp_now;
            end

            // slow offset loop, stepped so it stays below load dynamics
            if (st_reg.step == STEP_W'(OFFSET_STEP_CYC - 1))
            begin
                st_next.step = '0;
                if (OPTO_CURRENT < OPTO_TARGET_UA && st_reg.offset != OFFSET_MAX)
                    st_next.offset = st_reg.offset + 8'h01;  // [RQ1] [RQ2]
                else if (OPTO_CURRENT > OPTO_TARGET_UA && st_reg.offset != 8'h00)
                    st_next.offset = st_reg.offset - 8'h01;  // [RQ1] [RQ3]
            end
            else
                st_next.step = st_reg.step + STEP_W'(1);

            // fast swing lift follows the shortfall every cycle
            if (OPTO_CURRENT < OPTO_TARGET_UA)
                st_next.swing = OPTO_TARGET_UA - OPTO_CURRENT; // [RQ4]
            else
                st_next.swing = '0;

            // burst trigger and restart
            if (!LOWPOW_AT_MIN || st_reg.state != ST_RUN)
                st_next.burst = 1'b0;
            else if (!st_reg.burst && OPTO_CURRENT > BURST_START_UA)
                st_next.burst = 1'b1;                   // [RQ5]
            else if (st_reg.burst && OPTO_CURRENT < BURST_START_UA)
                st_next.burst_go = 1'b1;                // [RQ6]

            // protection state machine
            unique case (st_reg.state)
                ST_SUPPLY:
                begin
                    // recharging until both supplies are up
                    st_next.timer = '0;
                    if (supply_ok && !supply_uv)
                        st_next.state = ST_BOOST;       // [RQ8]
                end
                ST_BOOST:
                begin
                    // hold off until the boost stage is up
                    st_next.timer = '0;
                    if (supply_uv)
                        st_next.state = ST_SUPPLY;      // [RQ7]
                    else if (st_reg.boost_ok)
                        st_next.state = ST_RUN;         // [RQ10]
                end
                ST_RUN:
                begin
                    // overpower timer runs only while the swing is high
                    if (swing_opp && !OPP_TIMER_OFF)
                        st_next.timer = st_reg.timer + TIMER_W'(1);
                    else
                        st_next.timer = '0;
                    if (otp || ovp_trip)
                        st_next.state = ST_LATCHED;     // [RQ12] [RQ14]
                    else if (ocp_trip)
                        st_next.state = opp_dest;       // [RQ16]
                    else if (swing_opp && !OPP_TIMER_OFF
                             && st_reg.timer >= opp_limit - TIMER_W'(1))
                        st_next.state = opp_dest;       // [RQ20]
                    else if (supply_uv)
                        st_next.state = ST_SUPPLY;      // [RQ7]
                    else if (!st_reg.boost_ok)
                        st_next.state = ST_BOOST;       // [RQ11]
                    if (st_next.state != ST_RUN)
                        st_next.timer = '0;
                end
                ST_RESTART:
                begin
                    // pause, then go through the normal start checks
                    st_next.timer = st_reg.timer + TIMER_W'(1);
                    if (st_reg.timer >= TIMER_W'(RESTART - 1))
                    begin
                        st_next.timer = '0;
                        st_next.state = ST_SUPPLY;
                    end
                end
                ST_LATCHED:
                begin
                    // only a fresh power-on reset leaves this state
                    st_next.timer = '0;                 // [RQ15]
                end
                default:
                    st_next.state = ST_LATCHED;         // illegal code: fail safe
            endcase

            // outputs, registered from the coming state
            st_next.sw_en = (st_next.state == ST_RUN);
            st_next.hs_en = st_next.sw_en && bs_ok;     // [RQ9]
            st_next.cut = st_next.sw_en && ocp;         // [RQ16]
            // capacitive-mode turn-off never touches state or boost line
            st_next.cap_cut = st_next.sw_en && cap_near; // [RQ19]
            st_next.bst_oe = (st_next.state != ST_RUN)
                             && (st_next.state != ST_BOOST); // [RQ7] [RQ14]
            st_next.hv_chg = (st_next.state == ST_SUPPLY); // [RQ7]
            st_next.hv_reg = (st_next.state == ST_LATCHED)
                             || (st_next.state == ST_RESTART); // [RQ18]
        end
    end

    // ---------------------------------------------------------------
    // state register; reset is the only way out of a latch
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            st_reg <= '0;                           // [RQ15]
            st_reg.state <= ST_SUPPLY;
            st_reg.offset <= OFFSET_RST;
            st_reg.adc_sel <= ADC_OUT;
            st_reg.bst_oe <= 1'b1;
            st_reg.hv_chg <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // ---------------------------------------------------------------
    // outputs straight from the register, BOOST_SENSE_O tied low
    // ---------------------------------------------------------------
    assign SWITCH_EN = st_reg.sw_en;
    assign HS_GATE_EN = st_reg.hs_en;
    assign CONDUCTION_CUT = st_reg.cut;
    assign CAP_MODE_CUT = st_reg.cap_cut;
    assign BOOST_SENSE_O = 1'b0;
    assign BOOST_SENSE_OE = st_reg.bst_oe;
    assign HV_RECHARGE_EN = st_reg.hv_chg;
    assign HV_REG_START = st_reg.hv_reg;
    assign POWER_OFFSET = st_reg.offset;
    assign SWING_BOOST = st_reg.swing;
    assign BURST_MODE = st_reg.burst;
    assign BURST_START = st_reg.burst_go;
    assign ADC_SELECT = st_reg.adc_sel;
    assign PROT_STATE = st_reg.state;
endmodule : resonant_protection_and_optobias_fsm

// ===== dv/resonant_prot_chk.sv
// concurrent checks on the protection block ports
`timescale 1ns/10ps
module resonant_prot_chk
    import resonant_prot_pkg::*;
(
    input wire logic CLK, // clock
    input wire logic RSTN, // reset, low
    input wire logic [9:0] OPTO_CURRENT, // optocurrent
    input wire logic SWITCH_EN, // switching
    input wire logic HS_GATE_EN, // high side
    input wire logic BOOST_SENSE_O, // boost drive
    input wire logic BOOST_SENSE_OE, // boost pull
    input wire logic HV_REG_START, // supply hold
    input wire logic [7:0] POWER_OFFSET, // slow offset
    input wire logic [9:0] SWING_BOOST, // fast swing
    input wire logic BURST_START, // burst pulse
    input wire logic [2:0] PROT_STATE // state
);
    // one clock domain
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    run_only_a: assert property (SWITCH_EN |-> PROT_STATE == ST_RUN)
        else $error("switching outside run");
    hs_gate_a: assert property (HS_GATE_EN |-> SWITCH_EN)
        else $error("high side on while stopped");
    boost_pull_a: assert property (!(PROT_STATE inside {ST_BOOST, ST_RUN})
        |-> BOOST_SENSE_OE && !BOOST_SENSE_O) else $error("boost line not pulled");
    latch_hold_a: assert property (PROT_STATE == ST_LATCHED |=> PROT_STATE == ST_LATCHED)
        else $error("latch left");
    hv_reg_a: assert property (PROT_STATE inside {ST_RESTART, ST_LATCHED} |-> HV_REG_START)
        else $error("supply not held");
    swing_a: assert property (OPTO_CURRENT < OPTO_TARGET_UA |=>
        SWING_BOOST == 10'(OPTO_TARGET_UA - $past(OPTO_CURRENT))) else $error("swing wrong");
    step_a: assert property ($changed(POWER_OFFSET) |->
        8'(POWER_OFFSET - $past(POWER_OFFSET)) inside {8'h01, 8'hff}) else $error("big step");
    burst_a: assert property (BURST_START |-> $past(OPTO_CURRENT) < BURST_START_UA)
        else $error("burst start above level");
    cover property (PROT_STATE == ST_LATCHED);
    cover property (PROT_STATE == ST_RESTART);
    cover property (BURST_START);
endmodule : resonant_prot_chk
bind resonant_protection_and_optobias_fsm resonant_prot_chk i_chk (.CLK, .RSTN, .OPTO_CURRENT,
    .SWITCH_EN, .HS_GATE_EN, .BOOST_SENSE_O, .BOOST_SENSE_OE, .HV_REG_START, .POWER_OFFSET,
    .SWING_BOOST, .BURST_START, .PROT_STATE);

// ===== dv/pfc_model.sv
// companion boost stage as seen through the shared adc
`timescale 1ns/10ps
module pfc_model
(
    input wire logic clk, // clock
    input wire logic rstn, // reset, low
    input wire logic pull_low, // boost line pulled low
    input wire logic sel, // adc channel
    input wire logic [9:0] boost_code, // boost level
    input wire logic [9:0] out_code, // output level
    output logic valid, // sample strobe
    output logic [9:0] data // sample
);
    logic [1:0] div_reg; // a sample every fourth clock
    // a pulled line reads zero: the stage is off, not merely stale
    always_ff @(posedge clk or negedge rstn)
    begin
        div_reg <= rstn ? div_reg + 2'h1 : 2'h0;
        valid <= rstn && div_reg == 2'h3;
        data <= (!rstn || (sel && pull_low)) ? 10'h000 : (sel ? boost_code : out_code);
    end
endmodule : pfc_model

// ===== dv/testbench.sv
// self-checking bench for the protection and optobias block
`timescale 1ns/10ps
module testbench
    import resonant_prot_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, sup = 1'b0, bs = 1'b1, ocp = 1'b0, cyc = 1'b0;
    logic lp = 1'b0, ls = 1'b0, av, sw, hs, oe, bm, bst, sel, hvr, cut, cc, hvc;
    logic [9:0] opto = 10'h055, bc = 10'h000, oc = 10'h000, ad, swb;
    logic [7:0] off, b;
    logic [2:0] st;
    int error_cnt = 0, comparisons = 0;
    logic [19:0] rows [4] = '{20'h00055, 20'h15001, 20'h15400, 20'h32000}; // opto, swing
    always #25 clk = ~clk;
    resonant_protection_and_optobias_fsm #(.OPP_SHORT(20), .OPP_LONG(40), .RESTART(50)) i_dut (
        .CLK(clk), .RSTN(rstn), .CE(1'b1), .CONTROLLER_SUPPLY_BELOW_UV(!sup), .CONTROLLER_SUPPLY_ABOVE_START(sup),
        .REGULATED_SUPPLY_BELOW_UV(!sup), .REGULATED_SUPPLY_ABOVE_START(sup), .BOOTSTRAP_ABOVE_RST(bs),
        .OCP_COMP(ocp), .OTP_COMP(1'b0), .SWING_ABOVE_OPP(1'b0), .CAP_MODE_NEAR(ocp),
        .CYCLE_END(cyc), .ADC_VALID(av), .ADC_DATA(ad), .OPTO_CURRENT(opto),
        .LOWPOW_AT_MIN(lp), .OPP_LATCH_SEL(ls), .OPP_LONG_SEL(ls), .OPP_TIMER_OFF(1'b0),
        .SWITCH_EN(sw), .HS_GATE_EN(hs), .CONDUCTION_CUT(cut), .CAP_MODE_CUT(cc),
        .BOOST_SENSE_O(), .BOOST_SENSE_OE(oe), .HV_RECHARGE_EN(hvc), .HV_REG_START(hvr),
        .POWER_OFFSET(off), .SWING_BOOST(swb), .BURST_MODE(bm), .BURST_START(bst),
        .ADC_SELECT(sel), .PROT_STATE(st));
    pfc_model i_pfc (.clk(clk), .rstn(rstn), .pull_low(oe), .sel(sel), .boost_code(bc),
        .out_code(oc), .valid(av), .data(ad));
    // read at the edge: last cycle's values
    task check(input logic [9:0] seen, input logic [9:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task summarize;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // bounded wait; timeout is a mismatch
    task wait_st(input logic [2:0] s);
        int n;
        n = 0;
        while (st !== s && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        check(st, s, "state");
        if (n == 3000)
            summarize();
    endtask : wait_st
    // ocp early in cycle: sync lag stays inside
    task run(input int n, input logic f);
        repeat (n)
        begin
            ocp <= f;
            tick(3);
            ocp <= 1'b0;
            tick(4);
            cyc <= 1'b1;
            tick(1);
            cyc <= 1'b0;
        end
    endtask : run
    initial
    begin
        tick(16);
        rstn <= 1'b1;
        tick(2);
        check(st, ST_SUPPLY, "idle state");
        check(oe, 1'b1, "boost pull");
        check(hvc, 1'b1, "recharge");
        sup <= 1'b1;
        bc <= 10'h300;
        wait_st(ST_RUN);
        check(oe, 1'b0, "boost release");
        foreach (rows[i])
        begin
            opto <= rows[i][19:10];
            tick(3);
            check(swb, rows[i][9:0], "swing");
        end
        bs <= 1'b0;
        tick(5);
        check({sw, hs}, 2'h2, "bootstrap low");
        bs <= 1'b1;
        opto <= 10'h000;
        b = off;
        tick(4000);
        check(off > b, 1'b1, "offset up");
        opto <= 10'h0c8;
        b = off;
        tick(4000);
        check(off < b, 1'b1, "offset down");
        lp <= 1'b1;
        opto <= 10'h06b;
        tick(3);
        check(bm, 1'b1, "burst entry");
        opto <= 10'h064;
        tick(3);
        check(bst, 1'b1, "burst restart");
        lp <= 1'b0;
        opto <= 10'h055;
        bc <= 10'h100;
        wait_st(ST_BOOST);
        bc <= 10'h300;
        wait_st(ST_RUN);
        ocp <= 1'b1;
        tick(4);
        check({cut, cc}, 2'h3, "cuts");
        check(st, ST_RUN, "cap mode run");
        ocp <= 1'b0;
        tick(4);
        run(4, 1'b1);
        run(1, 1'b0);
        run(4, 1'b1);
        check(st, ST_RUN, "broken run");
        run(1, 1'b1);
        wait_st(ST_RESTART);
        check(hvr, 1'b1, "restart hold");
        wait_st(ST_RUN);
        oc <= 10'h3ff;
        run(4, 1'b0);
        check(st, ST_RUN, "short overvoltage");
        run(3, 1'b0);
        wait_st(ST_LATCHED);
        check(oe, 1'b1, "latched pull");
        oc <= 10'h000;
        tick(200);
        check(st, ST_LATCHED, "latch kept");
        rstn <= 1'b0;
        tick(2);
        check(st, ST_SUPPLY, "power cycle");
        summarize();
    end
endmodule : testbench
